// File: common/eoc_pkg.sv
package eoc_pkg;
    // upper address line codes, msb first (line 0, 1, 2)
    localparam logic [2:0] EOC_CODE_IDLE     = 3'h2;
    localparam logic [2:0] EOC_CODE_MASK_CLR = 3'h3;
    localparam logic [2:0] EOC_CODE_HHL      = 3'h6;
    localparam logic [2:0] EOC_CODE_HLH      = 3'h5;
    localparam logic [2:0] EOC_CODE_HHH      = 3'h7;

    // 11-bit opcodes of the external-control group
    localparam logic [10:0] EOC_OP_IDLE     = 11'h01a;
    localparam logic [10:0] EOC_OP_MASK_CLR = 11'h01b;
    localparam logic [10:0] EOC_OP_HHL      = 11'h01e;
    localparam logic [10:0] EOC_OP_HLH      = 11'h01d;
    localparam logic [10:0] EOC_OP_HHH      = 11'h01f;

    // base cost classes selected by the sequencer
    typedef enum logic [3:0] {
        EOC_CLS_ARITH  = 4'h0,  // word add, subtract, move
        EOC_CLS_CTXBR  = 4'h1,  // context-switch branch
        EOC_CLS_BRANCH = 4'h2,  // plain branch
        EOC_CLS_ABS_P  = 4'h3,  // absolute value, sign clear
        EOC_CLS_ABS_N  = 4'h4,  // absolute value, sign set
        EOC_CLS_EXT    = 4'h5,  // external-control group
        EOC_CLS_WPI    = 4'h6   // workspace pointer immediate load
    } eoc_cls_e;

    // base cycles / accesses per class
    localparam logic [7:0] EOC_CYC_ARITH  = 8'h0e;
    localparam logic [3:0] EOC_ACC_ARITH  = 4'h4;
    localparam logic [7:0] EOC_CYC_CTXBR  = 8'h1a;
    localparam logic [3:0] EOC_ACC_CTXBR  = 4'h6;
    localparam logic [7:0] EOC_CYC_BRANCH = 8'h08;
    localparam logic [3:0] EOC_ACC_BRANCH = 4'h2;
    localparam logic [7:0] EOC_CYC_ABS_P  = 8'h0c;
    localparam logic [3:0] EOC_ACC_ABS_P  = 4'h2;
    localparam logic [7:0] EOC_CYC_ABS_N  = 8'h0e;
    localparam logic [3:0] EOC_ACC_ABS_N  = 4'h3;
    localparam logic [7:0] EOC_CYC_EXT    = 8'h0c;
    localparam logic [3:0] EOC_ACC_EXT    = 4'h1;
    localparam logic [7:0] EOC_CYC_WPI    = 8'h0a;
    localparam logic [3:0] EOC_ACC_WPI    = 4'h2;

    // request from the sequencer: one instruction to time
    typedef struct packed {
        eoc_cls_e    cls;
        logic [10:0] opcode;       // used when cls is the external group
        logic [7:0]  extra_cyc;    // address-modification cycles
        logic [3:0]  extra_acc;    // address-modification accesses
        logic [3:0]  wait_states;  // wait states per memory access
    } eoc_req_s;

    localparam logic [1:0] EOC_ST_IDLE = 2'h0;
    localparam logic [1:0] EOC_ST_RUN  = 2'h1;
    localparam logic [1:0] EOC_ST_LAST = 2'h3;
    localparam logic [1:0] EOC_ST_HALT = 2'h2;
endpackage

// File: tb/eoc_core_sva.sv
module eoc_core_sva
    import eoc_pkg::*;
(
    input logic        clk_in,
    input logic        rstn_in,
    input logic        start_in,
    input eoc_req_s    req_in,
    input logic        wake_in,
    input logic        busy_out,
    input logic        halted_out,
    input logic [2:0]  upper_address_line_out,
    input logic        io_strobe_clock_out,
    input logic        microcycle_end_flag_n_out,
    input logic        mask_clear_out,
    input logic [15:0] total_cycles_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic tk;
    logic ext;
    // accepted start, and accepted external-group start
    assign tk  = start_in && !busy_out && !halted_out;
    assign ext = tk && req_in.cls == EOC_CLS_EXT;
    AST_STROBE: assert property (ext |-> ##1 !io_strobe_clock_out ##1 io_strobe_clock_out
        ##1 !io_strobe_clock_out) else $error("strobe not one pulse");
    AST_CODE_MCLR: assert property (ext && req_in.opcode == EOC_OP_MASK_CLR |=>
        upper_address_line_out == EOC_CODE_MASK_CLR && mask_clear_out) else $error("mask-clear");
    AST_CODE_HHH: assert property (ext && req_in.opcode == EOC_OP_HHH |=>
        upper_address_line_out == EOC_CODE_HHH && !mask_clear_out) else $error("code hhh");
    AST_HALT: assert property (ext && req_in.opcode == EOC_OP_IDLE |-> ##12 halted_out)
        else $error("no halt");
    AST_HALT_HOLD: assert property (halted_out && !wake_in |=> halted_out)
        else $error("halt left early");
    AST_FLAG: assert property (ext && req_in[15:0] == 16'h0000 |->
        ##1 microcycle_end_flag_n_out [*8] ##3 !microcycle_end_flag_n_out) else $error("flag time");
    AST_FLAG_ONE: assert property (!microcycle_end_flag_n_out |=> microcycle_end_flag_n_out)
        else $error("flag too long");
    AST_REFUSE: assert property (start_in && busy_out |=> $stable(total_cycles_out))
        else $error("busy start taken");
endmodule
bind eoc_core eoc_core_sva i_eoc_core_sva (.clk_in, .rstn_in, .start_in, .req_in, .wake_in,
    .busy_out, .halted_out, .upper_address_line_out, .io_strobe_clock_out,
    .microcycle_end_flag_n_out, .mask_clear_out, .total_cycles_out);

// File: tb/eoc_ext_ctl.sv
module eoc_ext_ctl
(
    input  logic       clk_in,
    input  logic       rstn_in,
    input  logic [2:0] addr_in,
    input  logic       strobe_in,
    output logic [2:0] code_out,
    output logic [7:0] count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // takes the code once per strobe pulse
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            code_out  <= 3'h0;
            count_out <= 8'h00;
        end
        else if (strobe_in)
        begin
            code_out  <= addr_in;
            count_out <= count_out + 8'h01;
        end
    end
endmodule

// File: tb/external_op_and_cycle_timing_tb.sv
module external_op_and_cycle_timing_tb
    import eoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, rstn_in = 1'b0, start_in = 1'b0, wake_in = 1'b0;
    eoc_req_s    req_in = '0;
    logic        busy_out, halted_out, io_strobe_clock_out, microcycle_end_flag_n_out;
    logic        mask_clear_out;
    logic [2:0]  upper_address_line_out, code;
    logic [7:0]  cnt;
    logic [15:0] total_cycles_out;
    int          fails = 0, total_checks = 0;
    always #5 clk_in = ~clk_in;
    eoc_core i_eoc_core (.clk_in, .rstn_in, .start_in, .req_in, .wake_in, .busy_out,
        .halted_out, .upper_address_line_out, .io_strobe_clock_out, .microcycle_end_flag_n_out,
        .mask_clear_out, .total_cycles_out);
    eoc_ext_ctl i_eoc_ext_ctl (.clk_in, .rstn_in, .addr_in(upper_address_line_out),
        .strobe_in(io_strobe_clock_out), .code_out(code), .count_out(cnt));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one instruction, cycles counted up to the end flag; rf adds a refused start
    task automatic go(input eoc_req_s r, input logic rf, output int n);
        req_in = r;
        start_in = 1'b1;
        @(posedge clk_in);
        #1 start_in = 1'b0;
        chk(16'(busy_out), 16'h0001);
        n = 2;
        if (rf)
            req_in.extra_cyc = 8'h40;
        while (microcycle_end_flag_n_out !== 1'b0)
        begin
            if (n > 400)
            begin
                fails++;
                wrap_up();
            end
            @(posedge clk_in);
            #1 n++;
            start_in = rf && n == 4;
        end
        // next start is legal only after the flag's cycle
        @(posedge clk_in);
        #1 chk(16'(busy_out), 16'h0000);
    endtask
    // back-to-back external ops, codes seen by the far side
    task automatic t_ext();
        logic [10:0] ops [4] = '{EOC_OP_MASK_CLR, EOC_OP_HHL, EOC_OP_HLH, EOC_OP_HHH};
        logic [2:0]  cds [4] = '{EOC_CODE_MASK_CLR, EOC_CODE_HHL, EOC_CODE_HLH, EOC_CODE_HHH};
        int n;
        for (int i = 0; i < 4; i++)
        begin
            go('{EOC_CLS_EXT, ops[i], 8'h00, 4'h0, 4'h0}, 1'b0, n);
            chk(16'(n), 16'h000c);
            chk(16'(code), 16'(cds[i]));
        end
        chk(16'(cnt), 16'h0004);
        $display("ext ops done");
    endtask
    // idle halts, refuses starts, wakes
    task automatic t_idle();
        int n;
        go('{EOC_CLS_EXT, EOC_OP_IDLE, 8'h00, 4'h0, 4'h0}, 1'b0, n);
        @(posedge clk_in);
        #1 start_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 start_in = 1'b0;
        chk(16'(halted_out), 16'h0001);
        chk(16'(cnt), 16'h0005);
        chk(16'(code), 16'(EOC_CODE_IDLE));
        wake_in = 1'b1;
        @(posedge clk_in);
        #1 wake_in = 1'b0;
        @(posedge clk_in);
        #1 chk(16'(halted_out), 16'h0000);
        go('{EOC_CLS_BRANCH, 11'h000, 8'h00, 4'h0, 4'h0}, 1'b0, n);
        chk(16'(n), 16'h0008);
        $display("idle done");
    endtask
    // cost classes with wait states and address modification
    task automatic t_cost();
        logic [27:0] tab [7] = '{28'h000000e, 28'h0081220, 28'h1000120, 28'h2000008,
            28'h3000312, 28'h4000111, 28'h600000a};
        logic [27:0] r;
        int n;
        for (int i = 0; i < 7; i++)
        begin
            r = tab[i];
            go('{eoc_cls_e'(r[27:24]), 11'h000, r[23:16], r[15:12], r[11:8]}, i == 1, n);
            chk(16'(n), 16'(r[7:0]));
            chk(total_cycles_out, 16'(r[7:0]));
        end
        $display("cost table done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        t_ext();
        t_cost();
        t_idle();
        wrap_up();
    end
endmodule

// File: verilog/eoc_core.sv
// How it works
// - external op: drive code, then one strobe pulse
// - codes per op; mask-clear also pulses mask_clear_out
// - idle halts until interrupt, load or reset
// - end flag low from final clock's edge
// - each access adds requested wait states
// - modified addressing adds cycles and accesses
// - arith 14/4, ctx 26/6, branch 8/2, abs
// - external ops 12/1, pointer load 10/2
module eoc_core
    import eoc_pkg::*;
(
    input  wire logic     clk_in,
    input  wire logic     rstn_in,
    input  wire logic     start_in,
    input  wire eoc_req_s req_in,
    input  wire logic     wake_in,
    output logic          busy_out,
    output logic          halted_out,
    output logic [2:0]    upper_address_line_out,
    output logic          io_strobe_clock_out,
    output logic          microcycle_end_flag_n_out,
    output logic          mask_clear_out,
    output logic [15:0]   total_cycles_out
);
    typedef enum logic [1:0] {
        EOC_S_IDLE = EOC_ST_IDLE,
        EOC_S_RUN  = EOC_ST_RUN,
        EOC_S_LAST = EOC_ST_LAST,
        EOC_S_HALT = EOC_ST_HALT
    } eoc_state_e;

    // sequencer state and pending flags
    eoc_state_e  state_r;
    logic [15:0] remain_r;
    logic        halt_pend_r;
    logic        strobe_due_r;

    // combinational decode of the request
    logic [15:0] total_nxt;
    logic [15:0] cyc_sum;
    logic [15:0] acc_sum;
    logic [7:0]  base_cyc;
    logic [3:0]  base_acc;
    logic [2:0]  code;
    logic        is_ext;
    logic        is_idle_op;
    logic        is_mclr_op;
    logic        take;

    // one step down the cycle budget
    function automatic logic [15:0] step_down(input logic [15:0] v);
        step_down = v - 16'h0001;
    endfunction

    // base cost lookup per class
    always_comb
    begin
        base_cyc = EOC_CYC_ARITH;
        base_acc = EOC_ACC_ARITH;
        case (req_in.cls)
            EOC_CLS_CTXBR:
            begin
                base_cyc = EOC_CYC_CTXBR;
                base_acc = EOC_ACC_CTXBR;
            end
            EOC_CLS_BRANCH:
            begin
                base_cyc = EOC_CYC_BRANCH;
                base_acc = EOC_ACC_BRANCH;
            end
            EOC_CLS_ABS_P:
            begin
                base_cyc = EOC_CYC_ABS_P;
                base_acc = EOC_ACC_ABS_P;
            end
            EOC_CLS_ABS_N:
            begin
                base_cyc = EOC_CYC_ABS_N;
                base_acc = EOC_ACC_ABS_N;
            end
            EOC_CLS_EXT:
            begin
                base_cyc = EOC_CYC_EXT;
                base_acc = EOC_ACC_EXT;
            end
            EOC_CLS_WPI:
            begin
                base_cyc = EOC_CYC_WPI;
                base_acc = EOC_ACC_WPI;
            end
            default:
            begin
                base_cyc = EOC_CYC_ARITH;
                base_acc = EOC_ACC_ARITH;
            end
        endcase
    end

    // T/tc = C + W*M, with modification added to C and M
    always_comb
    begin
        cyc_sum   = {8'h00, base_cyc} + {8'h00, req_in.extra_cyc};
        acc_sum   = {12'h000, base_acc} + {12'h000, req_in.extra_acc};
        total_nxt = cyc_sum + ({12'h000, req_in.wait_states} * acc_sum);
    end

    // a start is taken only from idle
    assign take = (state_r == EOC_S_IDLE) && start_in;

    // external op code decode
    always_comb
    begin
        is_ext     = (req_in.cls == EOC_CLS_EXT);
        is_idle_op = 1'b0;
        is_mclr_op = 1'b0;
        code       = EOC_CODE_IDLE;
        case (req_in.opcode)
            EOC_OP_IDLE:
            begin
                code       = EOC_CODE_IDLE;
                is_idle_op = is_ext;
            end
            EOC_OP_MASK_CLR:
            begin
                code       = EOC_CODE_MASK_CLR;
                is_mclr_op = is_ext;
            end
            // user-defined operations carry only a code
            EOC_OP_HHL: code = EOC_CODE_HHL;
            EOC_OP_HLH: code = EOC_CODE_HLH;
            EOC_OP_HHH: code = EOC_CODE_HHH;
            default:    code = EOC_CODE_IDLE;
        endcase
    end

    // sequence state and cycle counter
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_r     <= EOC_S_IDLE;
            remain_r    <= 16'h0000;
            halt_pend_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                EOC_S_IDLE:
                    if (start_in)
                    begin
                        remain_r    <= step_down(total_nxt);
                        halt_pend_r <= is_idle_op;
                        state_r     <= (total_nxt <= 16'h0001) ? EOC_S_LAST : EOC_S_RUN;
                    end
                // count down to the final clock
                EOC_S_RUN:
                begin
                    remain_r <= step_down(remain_r);
                    if (remain_r == 16'h0002)
                        state_r <= EOC_S_LAST;  // final clock begins next edge
                end
                EOC_S_LAST:
                begin
                    state_r    <= halt_pend_r ? EOC_S_HALT : EOC_S_IDLE;
                end
                EOC_S_HALT:
                    if (wake_in)
                    begin
                        halt_pend_r <= 1'b0;
                        state_r     <= EOC_S_IDLE;
                    end
                default: state_r <= EOC_S_IDLE;
            endcase
        end
    end

    // address code set at start, strobe one cycle later
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            upper_address_line_out <= 3'h0;
            strobe_due_r           <= 1'b0;
            io_strobe_clock_out    <= 1'b0;
            mask_clear_out         <= 1'b0;
        end
        else
        begin
            if (take && is_ext)
                upper_address_line_out <= code;
            strobe_due_r        <= take && is_ext;
            io_strobe_clock_out <= strobe_due_r;
            mask_clear_out      <= take && is_mclr_op;
        end
    end

    // status outputs
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            microcycle_end_flag_n_out <= 1'b1;
            busy_out                  <= 1'b0;
            halted_out                <= 1'b0;
            total_cycles_out          <= 16'h0000;
        end
        else
        begin
            microcycle_end_flag_n_out <= !((state_r == EOC_S_RUN && remain_r == 16'h0002)
                || (state_r == EOC_S_IDLE && start_in && total_nxt <= 16'h0001));
            busy_out   <= (state_r == EOC_S_IDLE) ? start_in
                        : (state_r != EOC_S_LAST && state_r != EOC_S_HALT);
            halted_out <= (state_r == EOC_S_LAST && halt_pend_r)
                       || (state_r == EOC_S_HALT && !wake_in);
            if (take)
                total_cycles_out <= total_nxt;
        end
    end
endmodule
